// [hdl/dprh_pkg.sv]
// shared constants and types for the double reconfiguration host sequencer
package dprh_pkg;

   // second-request delays after the first complete indication, in clocks
   localparam logic [3:0] DLY_PLAIN        = 4'h7;
   localparam logic [3:0] DLY_ENCRYPT      = 4'h6;
   localparam logic [3:0] DLY_COMPRESS     = 4'h2;
   // data starts this many clocks after accept
   localparam logic [3:0] DATA_LEAD        = 4'h4;
   // hold count at which the next compressed word loads; each word is held four clocks
   localparam logic [1:0] COMP_HOLD_LAST   = 2'h3;
   // lut memory block size and fill layout
   localparam int         LUT_BLOCK_BITS   = 640;
   localparam int         FILL_ADDR_W      = 10;
   localparam logic [9:0] FILL_LAST_DEF    = 10'h27F;
   localparam logic [3:0] RESET_HOLD       = 4'hF;
   localparam int         WORD_W           = 16;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0000,
      ST_FILL    = 4'b0001,
      ST_REQ1    = 4'b0010,
      ST_LEAD1   = 4'b0011,
      ST_DATA1   = 4'b0100,
      ST_GAP     = 4'b0101,
      ST_REQ2    = 4'b0110,
      ST_LEAD2   = 4'b0111,
      ST_DATA2   = 4'b1000,
      ST_BRINGUP = 4'b1001,
      ST_RELEASE = 4'b1010
   } dprh_state_type;

   // link toward the device control block
   typedef struct packed {
      logic              request;
      logic [WORD_W-1:0] data_word;
   } dprh_to_dev_type;

   typedef struct packed {
      logic accept;
      logic complete;
   } dprh_from_dev_type;

   // start options
   typedef struct packed {
      logic compress;
      logic encrypt;
      logic double_cycle;
      logic lut_fill;
   } dprh_opts_type;

endpackage

// [hdl/dprh_word_reg.sv]
// holding register for the data word presented to the device
`timescale 1ns/1ps
module dprh_word_reg
   import dprh_pkg::*;
(
   input  wire logic              core_clk,   // system clock
   input  wire logic              rst,        // async reset, high
   input  wire logic              load,       // capture new word
   input  wire logic [WORD_W-1:0] word_in,    // word from source
   output logic      [WORD_W-1:0] word_out    // registered word
);

   logic [WORD_W-1:0] word_r;
   logic [WORD_W-1:0] word_nxt;

   // next value: capture on load
   always_comb
   begin
      word_nxt = load ? word_in : word_r;
   end

   // register
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         word_r <= '0;
      else
         word_r <= word_nxt;
   end

   assign word_out = word_r;

endmodule

// [hdl/dprh_host.sv]
// host sequencer driving single and double partial reconfiguration
// What this block does
// - plain double cycle: second request exactly seven clocks after first complete.
// - encryption only: second request exactly six clocks after first complete.
// - compression on: second request exactly two clocks after first complete.
// - uncompressed: data words start four clocks after accept, both cycles.
// - data is don't-care from first complete until four clocks after second accept.
// - keep supplying data words until the second complete.
// - after second complete drop request, then reset region to known state.
// - compressed: stop advancing bitstream when first complete asserts.
// - compressed: resume data immediately once second accept asserts.
// - masked-merge with initialised block RAM needs a double cycle.
// - masked-merge: write ones into every used lut memory bit first.
// - lut memory blocks are 640 bits; fill writes bits 0 to fill_last, whole block or part.
// - clock-enable clear from static side, frozen before entry.
// - release clock-enable clear only as the very last step.
// - masked-merge regions hold no lut rom or preloaded lut ram.
// - compressed words are each held exactly four clocks.
`timescale 1ns/1ps
module dprh_host
   import dprh_pkg::*;
(
   input  wire logic                   core_clk,      // 100 MHz clock
   input  wire logic                   rst,           // async reset, high
   input  wire logic                   start,         // begin a reconfiguration
   input  wire dprh_opts_type          opts,          // options, sampled at start
   input  wire logic [FILL_ADDR_W-1:0] fill_last,     // last lut bit address used
   input  wire logic [WORD_W-1:0]      src_word,      // bitstream word from source
   input  wire logic                   src_valid,     // source has a word
   output logic                        src_ready,     // word consumed this cycle
   input  wire dprh_from_dev_type      dev_in,        // accept and complete
   output dprh_to_dev_type             dev_out,       // request and data word
   output logic                        fill_we,       // lut fill write strobe
   output logic [FILL_ADDR_W-1:0]      fill_addr,     // lut fill bit address
   output logic                        fill_bit,      // lut fill data
   output logic                        ce_clear,      // region clock-enable clear
   output logic                        region_reset,  // region reset for bring-up
   output logic                        busy,          // sequence running
   output logic                        done           // one-cycle finish pulse
);

   dprh_state_type           state_r, state_nxt;
   dprh_opts_type            opts_r, opts_nxt;
   logic [3:0]               cnt_r, cnt_nxt;
   logic [1:0]               hold_r, hold_nxt;
   logic [FILL_ADDR_W-1:0]   addr_r, addr_nxt;
   logic                     req_r, req_nxt;
   logic                     clr_r, clr_nxt;
   logic                     rrst_r, rrst_nxt;
   logic                     done_r, done_nxt;
   logic                     load;
   logic                     streaming;
   logic [WORD_W-1:0]        word_q;

   // second-request delay from the options
   function automatic logic [3:0] gap_delay(input dprh_opts_type o);
      if (o.compress)
         gap_delay = DLY_COMPRESS;
      else if (o.encrypt)
         gap_delay = DLY_ENCRYPT;
      else
         gap_delay = DLY_PLAIN;
   endfunction

   // data phases where words advance
   assign streaming = (state_r == ST_DATA1) || (state_r == ST_DATA2);
   assign load = streaming && src_valid && !dev_in.complete &&
                 (!opts_r.compress || hold_r == COMP_HOLD_LAST);
   assign src_ready = load;

   dprh_word_reg u_word
   (
      .core_clk (core_clk),
      .rst      (rst),
      .load     (load),
      .word_in  (src_word),
      .word_out (word_q)
   );

   // sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      opts_nxt  = opts_r;
      cnt_nxt   = cnt_r;
      addr_nxt  = addr_r;
      req_nxt   = req_r;
      clr_nxt   = clr_r;
      rrst_nxt  = rrst_r;
      done_nxt  = 1'b0;
      hold_nxt  = streaming ? hold_r + 2'h1 : 2'h0;
      if (load)
         hold_nxt = 2'h0;
      case (state_r)
         ST_IDLE:
         begin
            if (start)
            begin
               opts_nxt = opts;
               clr_nxt  = 1'b1;
               addr_nxt = '0;
               state_nxt = opts.lut_fill ? ST_FILL : ST_REQ1;
            end
         end
         ST_FILL:
         begin
            // fills bits 0 to fill_last, which need not end a block
            addr_nxt = addr_r + 1'b1;
            if (addr_r == fill_last)
               state_nxt = ST_REQ1;
         end
         ST_REQ1:
         begin
            req_nxt = 1'b1;
            if (dev_in.accept)
            begin
               // first compressed word taken at once
               hold_nxt  = COMP_HOLD_LAST;
               cnt_nxt   = 4'h1;
               state_nxt = opts_r.compress ? ST_DATA1 : ST_LEAD1;
            end
         end
         ST_LEAD1, ST_LEAD2:
         begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == DATA_LEAD - 4'h1)
               state_nxt = (state_r == ST_LEAD1) ? ST_DATA1 : ST_DATA2;
         end
         ST_DATA1:
         begin
            if (dev_in.complete)
            begin
               if (opts_r.double_cycle)
               begin
                  req_nxt   = 1'b0;
                  cnt_nxt   = 4'h1;
                  state_nxt = ST_GAP;
               end
               else
               begin
                  req_nxt   = 1'b0;
                  cnt_nxt   = '0;
                  state_nxt = ST_BRINGUP;
               end
            end
         end
         ST_GAP:
         begin
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == gap_delay(opts_r) - 4'h1)
            begin
               req_nxt   = 1'b1;
               state_nxt = ST_REQ2;
            end
         end
         ST_REQ2:
         begin
            if (dev_in.accept)
            begin
               cnt_nxt   = 4'h1;
               hold_nxt  = COMP_HOLD_LAST;
               state_nxt = opts_r.compress ? ST_DATA2 : ST_LEAD2;
            end
         end
         ST_DATA2:
         begin
            if (dev_in.complete)
            begin
               req_nxt   = 1'b0;
               cnt_nxt   = '0;
               state_nxt = ST_BRINGUP;
            end
         end
         ST_BRINGUP:
         begin
            rrst_nxt = 1'b1;
            cnt_nxt  = cnt_r + 4'h1;
            if (cnt_r == RESET_HOLD)
            begin
               rrst_nxt  = 1'b0;
               state_nxt = ST_RELEASE;
            end
         end
         ST_RELEASE:
         begin
            clr_nxt   = 1'b0;
            done_nxt  = 1'b1;
            state_nxt = ST_IDLE;
         end
         default:
         begin
            state_nxt = ST_IDLE;
            req_nxt   = 1'b0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= ST_IDLE;
         opts_r  <= '0;
         cnt_r   <= '0;
         hold_r  <= '0;
         addr_r  <= '0;
         req_r   <= 1'b0;
         clr_r   <= 1'b0;
         rrst_r  <= 1'b0;
         done_r  <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         opts_r  <= opts_nxt;
         cnt_r   <= cnt_nxt;
         hold_r  <= hold_nxt;
         addr_r  <= addr_nxt;
         req_r   <= req_nxt;
         clr_r   <= clr_nxt;
         rrst_r  <= rrst_nxt;
         done_r  <= done_nxt;
      end
   end

   // data word is free during the gap, holds last word
   // regions carry no preloaded lut memory; nothing to drive here
   assign dev_out.request   = req_r;
   assign dev_out.data_word = word_q;
   assign fill_we      = (state_r == ST_FILL);
   assign fill_addr    = addr_r;
   assign fill_bit     = 1'b1;
   assign ce_clear     = clr_r;
   assign region_reset = rrst_r;
   assign busy         = (state_r != ST_IDLE);
   assign done         = done_r;

endmodule

// [test/dprh_host_checker.sv]
// assertions for the reconfiguration host sequencer
`timescale 1ns/1ps
module dprh_host_checker
   import dprh_pkg::*;
(
   input wire logic              core_clk,     // clock
   input wire logic              rst,          // reset
   input wire logic              start,        // start
   input wire dprh_opts_type     opts,         // options
   input wire logic              src_valid,    // word present
   input wire logic              src_ready,    // word taken
   input wire dprh_from_dev_type dev_in,       // device status
   input wire dprh_to_dev_type   dev_out,      // request, data
   input wire logic              fill_we,      // fill strobe
   input wire logic              fill_bit,     // fill data
   input wire logic              ce_clear,     // enable clear
   input wire logic              region_reset, // region reset
   input wire logic              busy          // running
);
   logic       cmp_r;
   logic       enc_r;
   logic       dbl_r;
   logic       rq_r;
   logic       cp_r;
   logic [1:0] nrq_r;
   wire        req = dev_out.request;
   wire        fst = dbl_r && nrq_r == 2'h1 && dev_in.complete && !cp_r;
   // option latch and request phase count
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         {cmp_r, enc_r, dbl_r, rq_r, cp_r} <= 5'h00;
         nrq_r <= 2'h0;
      end
      else
      begin
         if (start && !busy)
         begin
            {cmp_r, enc_r, dbl_r} <= {opts.compress, opts.encrypt, opts.double_cycle};
            nrq_r <= 2'h0;
         end
         else if (req && !rq_r)
            nrq_r <= nrq_r + 2'h1;
         rq_r <= req;
         cp_r <= dev_in.complete;
      end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   gap_plain_a: assert property (fst && !cmp_r && !enc_r |-> ##1 (!req)[*6] ##1 req)
      else $error("second request not seven clocks after complete");
   gap_crypt_a: assert property (fst && !cmp_r && enc_r |-> ##1 (!req)[*5] ##1 req)
      else $error("second request not six clocks after complete");
   gap_comp_a: assert property (fst && cmp_r |-> ##1 !req ##1 req)
      else $error("second request not two clocks after complete");
   lead_four_a: assert property ($rose(dev_in.accept) && !cmp_r && src_valid
      |-> (!src_ready)[*4] ##1 src_ready) else $error("data lead is not four clocks");
   stop_done_a: assert property (dev_in.complete |-> !src_ready)
      else $error("word taken while complete");
   comp_resume_a: assert property ($rose(dev_in.accept) && cmp_r && src_valid
      |-> ##[0:1] src_ready) else $error("compressed data not resumed");
   comp_hold_a: assert property (cmp_r && src_ready |=> (!src_ready)[*3])
      else $error("compressed word not held four clocks");
   fill_ones_a: assert property (fill_we |-> fill_bit && !req)
      else $error("fill writes zero or overlaps request");
   clear_cover_a: assert property (req |-> ce_clear)
      else $error("clear low during request");
   clear_last_a: assert property ($fell(ce_clear) |-> !req && !region_reset)
      else $error("clear released before the end");
   bring_up_a: assert property ($rose(region_reset) |-> !req)
      else $error("region reset while requesting");
   second_req_c: cover property (fst);
   fill_run_c: cover property (fill_we);
   finish_c: cover property ($fell(ce_clear));
endmodule

bind dprh_host dprh_host_checker dprh_host_checker_i (.core_clk, .rst, .start, .opts,
   .src_valid, .src_ready, .dev_in, .dev_out, .fill_we, .fill_bit, .ce_clear,
   .region_reset, .busy);

// [test/dprh_dev_model.sv]
// device control block model: accept and complete per request
`timescale 1ns/1ps
module dprh_dev_model
   import dprh_pkg::*;
(
   input  wire logic            core_clk, // clock
   input  wire logic            rst,      // reset
   input  wire dprh_to_dev_type dev_out,  // from host
   input  wire logic [7:0]      acc_dly,  // accept delay
   input  wire logic [7:0]      len,      // data clocks
   output dprh_from_dev_type    dev_in    // to host
);
   logic [8:0] cnt_r;
   always_ff @(posedge core_clk or posedge rst)
      if (rst || !dev_out.request)
      begin
         cnt_r  <= 9'h000;
         dev_in <= 2'h0;
      end
      else
      begin
         cnt_r           <= cnt_r + 9'h001;
         dev_in.accept   <= cnt_r >= {1'b0, acc_dly};
         dev_in.complete <= cnt_r >= {1'b0, acc_dly} + {1'b0, len} + 9'h004;
      end
endmodule

// [test/tb_top.sv]
// self-checking bench for the reconfiguration host sequencer
`timescale 1ns/1ps
module tb_top
   import dprh_pkg::*;
;
   logic core_clk, rst, start, src_valid, src_ready, fill_we, fill_bit;
   logic ce_clear, region_reset, busy, done, rq_q, cp_q, ld_q;
   logic [9:0] fill_last, fill_addr;
   logic [15:0] src_word, w_q;
   logic [7:0] acc_dly, len;
   dprh_opts_type opts;
   dprh_from_dev_type dev_in;
   dprh_to_dev_type dev_out;
   int fails, checks, cyc, t_c, t_r, nrq, nfill, ndone, nrst;
   dprh_host dprh_host_i (.core_clk, .rst, .start, .opts, .fill_last, .src_word,
      .src_valid, .src_ready, .dev_in, .dev_out, .fill_we, .fill_addr, .fill_bit,
      .ce_clear, .region_reset, .busy, .done);
   dprh_dev_model dprh_dev_model_i (.core_clk, .rst, .dev_out, .acc_dly, .len, .dev_in);
   always #5 core_clk = ~core_clk;
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic logic [15:0] exp_gap(logic c, logic e);
      return c ? 16'(DLY_COMPRESS) : e ? 16'(DLY_ENCRYPT) : 16'(DLY_PLAIN);
   endfunction
   // phase timing, fill writes and word pass-through
   always @(posedge core_clk)
   begin
      cyc++;
      if (dev_in.complete && !cp_q && nrq == 1)
         t_c = cyc;
      if (dev_out.request && !rq_q)
      begin
         nrq++;
         t_r = cyc;
      end
      if (fill_we)
         check("fill_addr", 16'(fill_addr), 16'(nfill));
      nfill += int'(fill_we);
      ndone += int'(done);
      nrst += int'(region_reset);
      if (ld_q)
         check("data_word", dev_out.data_word, w_q);
      {ld_q, w_q, rq_q, cp_q} = {src_ready, src_word, dev_out.request, dev_in.complete};
   end
   // fresh source word every clock
   always @(negedge core_clk)
      src_word <= 16'($urandom);
   task automatic run(logic c, logic e, logic d, logic f);
      int n;
      {nrq, nfill, ndone, nrst, n} = '0;
      opts = {c, e, d, f};
      fill_last = $urandom_range(1) ? FILL_LAST_DEF : 10'($urandom_range(639));
      acc_dly = 8'($urandom_range(9, 1));
      len = 8'($urandom_range(40, 5));
      start = 1'b1;
      while (!done && n < 5000)
      begin
         @(negedge core_clk);
         n++;
         start = n == 20;
      end
      repeat (3) @(negedge core_clk);
      if (d)
         check("gap", 16'(t_r - t_c), exp_gap(c, e));
      check("requests", 16'(nrq), d ? 16'h0002 : 16'h0001);
      if (f)
         check("fill", 16'(nfill), 16'(fill_last) + 16'h0001);
      check("done", 16'(ndone), 16'h0001);
      check("reset_len", 16'(nrst), 16'(RESET_HOLD));
      check("clear", 16'(ce_clear), 16'h0000);
      check("busy", 16'(busy), 16'h0000);
   endtask
   initial
   begin
      {core_clk, rst, start, src_valid, opts, src_word} = {2'b01, 2'b01, 4'h0, 16'h0000};
      {fill_last, acc_dly, len, fails, checks, cyc} = {FILL_LAST_DEF, 16'h0105, 96'h0};
      void'($urandom(32'h03DFBCD8));
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      for (int i = 0; i < 8; i++)
         run(i[0], i[1], i != 7, i[2]);
      close_out;
   end
   // watchdog: eight runs of under 5000 clocks
   initial
   begin
      #400000;
      fails++;
      close_out;
   end
endmodule
